// [design/otp_program.sv]
// How it works
// - A 16384 by 8-bit array is written and read back through the programming pins.
// - The address counter moves only on pulses of the programming clock pin, or back to zero in zero-clear mode.
// - Data moves on an 8-bit two-way bus split in two nibbles, driven only while verifying.
// - Modes act only while the raised supply and programming voltage are both present.
// - Mode pins decode to zero-clear, write, verify and inhibit per the documented table.
// - Every fourth clock pulse in write or verify mode increments the address counter by one.
// - In verify mode the byte at the current address is driven onto the bus.
`timescale 1ns/100ps
`include "otp_cfg.svh"
module otp_program
	import otp_pkg::*;
#(
	parameter int DEPTH = `OTP_DEPTH,
	parameter int AW = `OTP_ADDR_W
) (
	input wire logic ref_clk_in, // 25 MHz system clock
	input wire logic reset_n_in, // Async reset, active low
	input wire logic prog_clock_in, // Address update clock pin
	input wire logic prog_clock_inverse_in, // Complement clock pin
	input wire logic supply_raised_in, // Supply at programming level
	input wire logic prog_voltage_in, // Programming voltage present
	input wire logic mode_select_bit0_in, // Mode pin 0
	input wire logic mode_select_bit1_in, // Mode pin 1
	input wire logic mode_select_bit2_in, // Mode pin 2
	input wire logic mode_select_bit3_in, // Mode pin 3
	input wire logic [3:0] prog_data_low_nibble_in, // Bus low nibble, pin level
	input wire logic [3:0] prog_data_high_nibble_in, // Bus high nibble, pin level
	output logic [3:0] prog_data_low_nibble_out, // Bus low nibble drive
	output logic [3:0] prog_data_high_nibble_out, // Bus high nibble drive
	output logic prog_data_oe_out, // High while device drives bus
	output logic [AW-1:0] prog_address_out, // Current address counter
	output logic clock_pair_fault_out // Clock pins not complementary, in any mode but idle
);
	// Cells start blank; reset leaves them alone, as a fused cell would
	logic [`OTP_DATA_W-1:0] mem [DEPTH] = '{default: `OTP_BLANK};
	logic [15:0] pins_sync;
	logic clk_s, clk_inv_s, supply_s, vpp_s;
	logic [3:0] md_s;
	logic [7:0] data_s;
	logic clk_prev;
	logic clk_rise;
	logic [1:0] pulse_cnt;
	logic [AW-1:0] addr;
	otp_mode_type mode;
	logic [7:0] read_data;
	logic drive;

	// Every pin passes two flops first
	otp_sync #(.WIDTH(16)) u_sync (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.async_in({prog_clock_in, prog_clock_inverse_in, supply_raised_in, prog_voltage_in,
			mode_select_bit3_in, mode_select_bit2_in, mode_select_bit1_in,
			mode_select_bit0_in, prog_data_high_nibble_in, prog_data_low_nibble_in}),
		.sync_out(pins_sync)
	);
	assign {clk_s, clk_inv_s, supply_s, vpp_s, md_s, data_s} = pins_sync;

	// Mode decode, gated by both supply conditions
	always_comb
	begin
		mode = otp_idle;
		if (supply_s && vpp_s)
		begin
			case (md_s)
				`OTP_CODE_ZERO_CLEAR: mode = otp_zero_clear;
				`OTP_CODE_WRITE: mode = otp_write;
				`OTP_CODE_VERIFY: mode = otp_verify;
				`OTP_CODE_INHIBIT_A, `OTP_CODE_INHIBIT_B: mode = otp_inhibit;
				default: mode = otp_idle;
			endcase
		end
	end

	// Edge detect on the synchronised clock pin
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			clk_prev <= 1'b0;
		else
			clk_prev <= clk_s;
	end
	assign clk_rise = clk_s && !clk_prev;

	// Address counter, stepping on every fourth pulse in write or verify mode
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			pulse_cnt <= 2'h0;
			addr <= '0;
		end
		else if (mode == otp_zero_clear)
		begin
			pulse_cnt <= 2'h0;
			addr <= '0;
		end
		else if (clk_rise && (mode == otp_write || mode == otp_verify))
		begin
			pulse_cnt <= pulse_cnt + 2'h1;
			if (pulse_cnt == `OTP_PULSES_PER_STEP)
				addr <= addr + 1'b1;
		end
	end
	assign prog_address_out = addr;

	// Array write; one-time cells only pull bits low, inhibit leaves cells alone
	always_ff @(posedge ref_clk_in)
	begin
		if (mode == otp_write)
			mem[addr] <= mem[addr] & data_s;
	end

	// Read path and bus drive, registered
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			read_data <= 8'h00;
			drive <= 1'b0;
		end
		else
		begin
			read_data <= mem[addr];
			drive <= (mode == otp_verify);
		end
	end
	assign prog_data_low_nibble_out = read_data[3:0];
	assign prog_data_high_nibble_out = read_data[7:4];
	assign prog_data_oe_out = drive;

	// Flag only; the device keeps working on the main clock pin
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			clock_pair_fault_out <= 1'b0;
		else
			clock_pair_fault_out <= (mode != otp_idle) && (clk_s == clk_inv_s);
	end

	property p_bus_only_verify;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		prog_data_oe_out |-> $past(mode) == otp_verify;
	endproperty
	a_bus_only_verify: assert property (p_bus_only_verify) else $error("bus driven outside verify");

	property p_no_mode_unpowered;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		!(supply_s && vpp_s) |-> mode == otp_idle;
	endproperty
	a_no_mode_unpowered: assert property (p_no_mode_unpowered) else $error("mode without voltage");

	property p_zero_clear;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		mode == otp_zero_clear |=> addr == '0;
	endproperty
	a_zero_clear: assert property (p_zero_clear) else $error("zero clear failed");

	property p_step_on_fourth;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		addr != $past(addr) && $past(mode) != otp_zero_clear |->
			$past(pulse_cnt) == 2'h3 && $past(clk_rise) && addr == $past(addr) + 1'b1;
	endproperty
	a_step_on_fourth: assert property (p_step_on_fourth) else $error("bad address step");

	property p_inhibit_hold;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		mode == otp_inhibit |=> addr == $past(addr) && !prog_data_oe_out;
	endproperty
	a_inhibit_hold: assert property (p_inhibit_hold) else $error("inhibit changed state");

	property p_verify_data;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		mode == otp_verify |=> read_data == mem[$past(addr)];
	endproperty
	a_verify_data: assert property (p_verify_data) else $error("verify data wrong");

	property p_clock_only;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		!$past(clk_rise) && $past(mode) != otp_zero_clear |-> $stable(pulse_cnt);
	endproperty
	a_clock_only: assert property (p_clock_only) else $error("count moved without pulse");

	property p_write_lowers;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		mode == otp_write |=> (mem[$past(addr)] & ~$past(data_s)) == 8'h00;
	endproperty
	a_write_lowers: assert property (p_write_lowers) else $error("write not stored");

	property p_step_taken;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		clk_rise && pulse_cnt == `OTP_PULSES_PER_STEP && (mode == otp_write || mode == otp_verify)
			|=> addr == $past(addr) + 1'b1;
	endproperty
	a_step_taken: assert property (p_step_taken) else $error("fourth pulse did not step");

	property p_idle_hold;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		mode == otp_idle || mode == otp_inhibit |=> $stable(pulse_cnt) && $stable(addr);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("count moved while idle");

	property p_verify_drives;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		mode == otp_verify |=> prog_data_oe_out;
	endproperty
	a_verify_drives: assert property (p_verify_drives) else $error("verify left bus idle");

	property p_write_no_drive;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		mode == otp_write |=> !prog_data_oe_out;
	endproperty
	a_write_no_drive: assert property (p_write_no_drive) else $error("bus driven in write");

	property p_pair_fault;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		mode != otp_idle && clk_s == clk_inv_s |=> clock_pair_fault_out;
	endproperty
	a_pair_fault: assert property (p_pair_fault) else $error("clock pair fault missed");
endmodule

// [design/otp_cfg.svh]
`ifndef OTP_CFG_SVH
`define OTP_CFG_SVH
// Array geometry
`define OTP_DEPTH 16384
`define OTP_ADDR_W 14
`define OTP_DATA_W 8
// Last pulse index of an address step; four pulses per step
`define OTP_PULSES_PER_STEP 2'h3
// Erased cell value of a one-time cell
`define OTP_BLANK 8'hFF
// Mode pin codes, bit 3 down to bit 0
`define OTP_CODE_ZERO_CLEAR 4'h5
`define OTP_CODE_WRITE 4'hE
`define OTP_CODE_VERIFY 4'hC
`define OTP_CODE_INHIBIT_A 4'hD
`define OTP_CODE_INHIBIT_B 4'hF
`endif

// [design/otp_pkg.sv]
package otp_pkg;
	typedef enum logic [2:0] {otp_idle, otp_zero_clear, otp_write, otp_verify, otp_inhibit}
		otp_mode_type;
endpackage

// [design/otp_sync.sv]
`timescale 1ns/100ps
// Two-flop synchroniser for a pin level
module otp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk_in, // System clock
	input wire logic reset_n_in, // Async reset, active low
	input wire logic [WIDTH-1:0] async_in, // Pin levels
	output logic [WIDTH-1:0] sync_out // Synchronised levels
);
	logic [WIDTH-1:0] stage1;

	// First stage read only by the second
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// [testbench/otp_programmer.sv]
`timescale 1ns/100ps
// Programmer model: mode, clock pair, voltages and bus drive
module otp_programmer #(
	parameter int MS_CYCLES = 25000,
	parameter int SETTLE_CYCLES = 250
) (
	input wire logic ref_clk_in, // Bench clock
	input wire logic [7:0] bus_in, // Resolved bus level
	output logic clk_out, // Address clock pin
	output logic clk_inv_out, // Complement pin
	output logic [3:0] mode_out, // Mode pins 3..0
	output logic vpp_out, // Programming voltages
	output logic [7:0] data_out, // Bus drive value
	output logic drive_out // High while model drives bus
);
	logic pair_break; // Test hook, breaks the clock pair

	// Clock held low until pulses are wanted
	initial
	begin
		pair_break = 1'h0;
		clk_out = 1'h0;
		mode_out = 4'h0;
		vpp_out = 1'h0;
		data_out = 8'h00;
		drive_out = 1'h0;
	end
	assign clk_inv_out = ~clk_out ^ pair_break;
	task automatic put(input logic [3:0] m, input int n);
		mode_out <= m;
		repeat (n) @(posedge ref_clk_in);
	endtask
	task automatic bus(input logic [7:0] d, input logic on);
		data_out <= d;
		drive_out <= on;
	endtask
	// Settle, zero-clear, then raise voltages
	task automatic start();
		put(4'h0, SETTLE_CYCLES);
		put(4'h5, 4);
		vpp_out <= 1'h1;
		put(4'h5, 4);
	endtask
	task automatic pulses(input int n);
		repeat (n)
		begin
			clk_out <= 1'h1;
			repeat (3) @(posedge ref_clk_in);
			clk_out <= 1'h0;
			repeat (3) @(posedge ref_clk_in);
		end
	endtask
	// Inhibit around write; bus taken only once the device has let go
	task automatic burn(input logic [7:0] d, input int n);
		put(4'hD, 4);
		bus(d, 1'h1);
		put(4'hE, n);
		put(4'hD, 4);
		bus(d, 1'h0);
	endtask
	task automatic program_byte(input logic [7:0] d, output int tries);
		tries = 0;
		do
		begin
			burn(d, MS_CYCLES);
			put(4'hC, 5);
			tries++;
		end
		while (bus_in !== d && tries < 3);
		burn(d, tries * MS_CYCLES);
	endtask
endmodule

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb;
	logic ref_clk, reset_n, supply, pclk, pclk_n, vpp, pdrive, oe, fault;
	logic [3:0] mode, lo, hi;
	logic [7:0] pdata;
	logic [13:0] addr;
	wire logic [7:0] bus;
	int n_mismatch = 0;
	int check_count = 0;
	int tries;
	// Pull-downs hold the bus low when nobody drives it
	assign bus = oe ? {hi, lo} : (pdrive ? pdata : 8'h00);
	otp_programmer #(.MS_CYCLES(10)) prog (.ref_clk_in(ref_clk),
		.bus_in(bus), .clk_out(pclk), .clk_inv_out(pclk_n), .mode_out(mode),
		.vpp_out(vpp), .data_out(pdata), .drive_out(pdrive));
	otp_program dut (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .prog_clock_in(pclk),
		.prog_clock_inverse_in(pclk_n), .supply_raised_in(supply), .prog_voltage_in(vpp),
		.mode_select_bit0_in(mode[0]), .mode_select_bit1_in(mode[1]),
		.mode_select_bit2_in(mode[2]), .mode_select_bit3_in(mode[3]),
		.prog_data_low_nibble_in(bus[3:0]), .prog_data_high_nibble_in(bus[7:4]),
		.prog_data_low_nibble_out(lo), .prog_data_high_nibble_out(hi),
		.prog_data_oe_out(oe), .prog_address_out(addr), .clock_pair_fault_out(fault));
	initial
	begin
		ref_clk = 1'h0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Blank read, then two bytes programmed and read back in order
	task automatic t_program();
		supply <= 1'h1;
		prog.start();
		prog.put(4'hC, 5);
		check({8'h00, bus}, 16'h00FF);
		check({15'h0, oe}, 16'h0001);
		prog.program_byte(8'hA5, tries);
		check(16'(tries), 16'h0001);
		prog.put(4'hC, 5);
		prog.pulses(3);
		check({2'h0, addr}, 16'h0000);
		prog.pulses(1);
		check({2'h0, addr}, 16'h0001);
		prog.program_byte(8'h3C, tries);
		check(16'(tries), 16'h0001);
		prog.put(4'hC, 5);
		prog.pulses(4);
		check({2'h0, addr}, 16'h0002);
		prog.put(4'h5, 5);
		check({2'h0, addr}, 16'h0000);
		prog.put(4'hC, 5);
		check({8'h00, bus}, 16'h00A5);
		prog.pulses(4);
		check({8'h00, bus}, 16'h003C);
	endtask
	// Both inhibit codes, then write pins without supply, then without voltage
	task automatic t_blocked();
		for (int i = 0; i < 4; i++)
		begin
			if (i == 2)
				supply <= 1'h0;
			if (i == 3)
			begin
				supply <= 1'h1;
				prog.vpp_out <= 1'h0;
			end
			prog.put(i == 0 ? 4'hD : (i == 1 ? 4'hF : 4'hE), 4);
			if (i == 0)
				prog.bus(8'h00, 1'h1);
			prog.pulses(4);
			check({2'h0, addr}, 16'h0001);
			check({15'h0, oe}, 16'h0000);
		end
		prog.put(4'hD, 4);
		prog.bus(8'h00, 1'h0);
		prog.vpp_out <= 1'h1;
		prog.put(4'hC, 5);
		check({8'h00, bus}, 16'h003C);
		prog.pair_break <= 1'h1;
		prog.put(4'hC, 5);
		check({15'h0, fault}, 16'h0001);
		prog.pair_break <= 1'h0;
		prog.put(4'h5, 5);
		check({2'h0, addr}, 16'h0000);
		check({15'h0, fault}, 16'h0000);
	endtask
	initial
	begin
		reset_n = 1'h0;
		supply = 1'h0;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'h1;
		@(posedge ref_clk);
		check({2'h0, addr}, 16'h0000);
		t_program();
		t_blocked();
		complete_run();
	end
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		complete_run();
	end
endmodule
